// File: logic/lcdch_consts.vh
`ifndef LCDCH_CONSTS_VH
`define LCDCH_CONSTS_VH
// register byte addresses
`define LCDCH_A_CTRL 8'h00
`define LCDCH_A_CMD 8'h04
`define LCDCH_A_CDAT 8'h08
`define LCDCH_A_STAT 8'h20
`define LCDCH_A_RSP 8'h24
`define LCDCH_A_RDAT 8'h28
`define LCDCH_A_PINS 8'h40
// field positions
`define LCDCH_CTRL_GO 0
`define LCDCH_STAT_BUSY 0
`define LCDCH_STAT_RDY 1
// packet classes in the top two bits of the type byte
`define LCDCH_CLS_CMD 2'b00
`define LCDCH_CLS_RSP 2'b01
`define LCDCH_CLS_ERR 2'b11
`define LCDCH_MAX_LEN 8'h16
`define LCDCH_PING_MAX 8'h10
// memory geometry
`define LCDCH_COLS 5'h14
`define LCDCH_ROWS 2'h3
`define LCDCH_TEXT_LAST 7'h4f
`define LCDCH_GLYPH_LAST 7'h3f
`define LCDCH_SPACE 8'h20
`define LCDCH_STYLE_MAX 8'h04
// restart payload keys
`define LCDCH_KEY_BOOT 24'h08_1263
`define LCDCH_KEY_HRST 24'h0c_1c61
`define LCDCH_KEY_HOFF 24'h03_0b5f
// answer deadline and host pin pulse
`define LCDCH_ANSWER_MS 250
`define LCDCH_CLK_KHZ 40000
`define LCDCH_ANSWER_CYCLES (`LCDCH_ANSWER_MS * `LCDCH_CLK_KHZ)
`define LCDCH_PULSE_CYCLES 16'h9c40
// axi responses
`define LCDCH_OKAY 2'b00
`define LCDCH_SLVERR 2'b10
`endif

// File: logic/lcdch_top.v
// Notes on behaviour
// - every accepted command gets exactly one answer
// - answer type low six bits echo code
// - ping code 0x00, payload up to 16
// - ping answer 0x40 echoes length and bytes
// - version query answers 0x41, 16 ascii bytes
// - user area write needs 16 bytes, 0x42
// - code 0x03 returns stored user area
// - power-up loads boot state, factory welcome
// - code 0x04 saves display state, answers 0x44
// - reporting and watchdog settings never saved
// - payload 8,18,99 restarts the module
// - payload 12,28,97 pulses host reset
// - payload 3,11,95 pulses host power off
// - accepted restart payloads answer 0x45
// - clear fills text with 0x20, cursor home
// - glyph rows top first, values 0-63
// - row bit 7 blinks; glyph answer 0x49
// - readback answers 0x4a, address plus eight
// - readback address decode glyph and lines
// - cursor column 0-19 row 0-3, 0x4b
// - cursor styles 0-4, answer 0x4c
// - top type bits classify packet
// - crc trails packet, low byte first; this register interface carries no crc and none is checked or sent
// - answer every packet within 250 ms
// - payload length 0 to 22
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`include "lcdch_consts.vh"
module lcdch_top #(
    parameter [15:0] HOST_PULSE_CYCLES = `LCDCH_PULSE_CYCLES, // host pin pulse length
    parameter [127:0] VERSION_STR = "LCDX00:h0.0,z0.0" // value is arbitrary
) (
    input wire aclk, // 40 mhz clock
    input wire aresetn, // synchronous reset, low
    input wire [7:0] s_axi_awaddr, // write address
    input wire s_axi_awvalid, // write address valid
    output wire s_axi_awready, // write address ready
    input wire [31:0] s_axi_wdata, // write data
    input wire [3:0] s_axi_wstrb, // byte strobes
    input wire s_axi_wvalid, // write data valid
    output wire s_axi_wready, // write data ready
    output reg [1:0] s_axi_bresp, // write response
    output reg s_axi_bvalid, // write response valid
    input wire s_axi_bready, // write response ready
    input wire [7:0] s_axi_araddr, // read address
    input wire s_axi_arvalid, // read address valid
    output wire s_axi_arready, // read address ready
    output reg [31:0] s_axi_rdata, // read data
    output reg [1:0] s_axi_rresp, // read response
    output reg s_axi_rvalid, // read data valid
    input wire s_axi_rready, // read data ready
    output reg host_reset_o, // host reset pulse, high
    output reg host_power_off_o, // host power off pulse, high
    output reg rsp_event_o // one cycle when an answer posts
);
    localparam S_IDLE = 3'd0, S_EXEC = 3'd1, S_FILL = 3'd2, S_READ = 3'd3, S_DONE = 3'd4;
    localparam OP_CLEAR = 2'd0, OP_SAVE = 2'd1, OP_LOAD = 2'd2;
    integer i, j, k; // loop indices, one per process
    ////////////////////////////////////////////////////////////////////////
    // storage
    reg [7:0] cmd_b [0:23]; // command payload bytes
    reg [7:0] rsp_b [0:23]; // answer payload bytes
    reg [7:0] text_q [0:79]; // display_text_memory
    reg [7:0] glyph_q [0:63]; // glyph_pattern_memory
    reg [7:0] nv_text [0:79]; // boot copy of text
    reg [7:0] nv_glyph [0:63]; // boot copy of glyphs
    reg [7:0] nv_user [0:15]; // user nonvolatile area
    reg [7:0] cmd_type_q, cmd_len_q, rsp_type_q, rsp_len_q; // command and answer headers
    reg [2:0] state_q; // sequencer state
    reg [1:0] op_q; // fill loop operation
    reg [6:0] idx_q; // loop index
    reg post_q; // fill ends in an answer
    reg rsp_rdy_q; // sticky answer ready
    reg [4:0] col_q, nv_col; // cursor column, live and saved
    reg [1:0] row_q, nv_row; // cursor row, live and saved
    reg [2:0] style_q, nv_style; // cursor style, live and saved
    reg nv_valid_q; // boot copy holds data
    reg rb_glyph_q; // readback from glyphs
    reg [6:0] rb_base_q; // readback start
    reg [15:0] pulse_cnt_q; // host pin pulse timer
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel, address and data taken in either order
    reg aw_ok_q, w_ok_q; // halves held until the answer
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    wire wr_fire = aw_ok_q & w_ok_q & ~s_axi_bvalid; // both halves held
    wire busy = (state_q != S_IDLE);
    wire wr_cdat = (aw_addr_q[7:5] == 3'd0) && (aw_addr_q[4:2] >= 3'd2);
    wire wr_map = (aw_addr_q == `LCDCH_A_CTRL) || (aw_addr_q == `LCDCH_A_CMD) ||
                  (aw_addr_q == `LCDCH_A_STAT) || wr_cdat;
    wire [2:0] wr_word = aw_addr_q[4:2] - 3'd2;
    // go and payload edits are ignored while busy so the command stays put
    wire go = wr_fire && !busy && (aw_addr_q == `LCDCH_A_CTRL) && w_strb_q[0] && w_data_q[`LCDCH_CTRL_GO];
    wire rdy_clr = wr_fire && (aw_addr_q == `LCDCH_A_STAT) && w_strb_q[0] && w_data_q[`LCDCH_STAT_RDY];
    assign s_axi_awready = ~aw_ok_q;
    assign s_axi_wready = ~w_ok_q;
    // write side handshakes
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_ok_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_ok_q <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `LCDCH_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_ok_q) begin
                aw_ok_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_ok_q) begin
                w_ok_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_ok_q <= 1'b0;
                w_ok_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_map ? `LCDCH_OKAY : `LCDCH_SLVERR; // read-only or unmapped
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    // command registers, held while the sequencer runs
    always @(posedge aclk) begin
        if (!aresetn) begin
            cmd_type_q <= 8'h00;
            cmd_len_q <= 8'h00;
            for (k = 0; k < 24; k = k + 1) cmd_b[k] <= 8'h00;
        end else if (wr_fire && !busy) begin
            if (aw_addr_q == `LCDCH_A_CMD) begin
                if (w_strb_q[0]) cmd_type_q <= w_data_q[7:0];
                if (w_strb_q[1]) cmd_len_q <= w_data_q[15:8];
            end
            if (wr_cdat) begin
                for (k = 0; k < 4; k = k + 1) if (w_strb_q[k]) cmd_b[wr_word * 4 + k] <= w_data_q[8 * k +: 8];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel, answers one cycle after the address
    reg [31:0] rd_word;
    reg rd_err;
    wire [2:0] rw_c = s_axi_araddr[4:2] - 3'd2;
    wire [3:0] rw_r = s_axi_araddr[5:2] - 4'd10;
    assign s_axi_arready = ~s_axi_rvalid;
    // read decode
    always @* begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        if (s_axi_araddr == `LCDCH_A_CTRL) begin
            rd_word = 32'h0000_0000;
        end else if (s_axi_araddr == `LCDCH_A_CMD) begin
            rd_word = {16'h0000, cmd_len_q, cmd_type_q};
        end else if (s_axi_araddr[7:5] == 3'd0 && s_axi_araddr[4:2] >= 3'd2 && s_axi_araddr[1:0] == 2'd0) begin
            rd_word = {cmd_b[rw_c * 4 + 3], cmd_b[rw_c * 4 + 2], cmd_b[rw_c * 4 + 1], cmd_b[rw_c * 4]};
        end else if (s_axi_araddr == `LCDCH_A_STAT) begin
            rd_word = {11'h000, style_q, row_q, 3'h0, col_q, 6'h00, rsp_rdy_q, busy};
        end else if (s_axi_araddr == `LCDCH_A_RSP) begin
            rd_word = {16'h0000, rsp_len_q, rsp_type_q};
        end else if (s_axi_araddr >= `LCDCH_A_RDAT && s_axi_araddr < `LCDCH_A_PINS && s_axi_araddr[1:0] == 2'd0) begin
            rd_word = {rsp_b[rw_r * 4 + 3], rsp_b[rw_r * 4 + 2], rsp_b[rw_r * 4 + 1], rsp_b[rw_r * 4]};
        end else if (s_axi_araddr == `LCDCH_A_PINS) begin
            rd_word = {30'h0000_0000, host_power_off_o, host_reset_o};
        end else begin
            rd_err = 1'b1; // unmapped reads as zero with slverr
        end
    end
    // read data register
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `LCDCH_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_err ? `LCDCH_SLVERR : `LCDCH_OKAY;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // command checks
    wire [5:0] code = cmd_type_q[5:0];
    wire [23:0] key = {cmd_b[0], cmd_b[1], cmd_b[2]};
    wire [7:0] ra = cmd_b[0]; // readback address code
    wire ra_glyph = (ra[7:6] == 2'b01);
    wire ra_text = ra[7] && (ra[4:0] < `LCDCH_COLS);
    reg glyph_bad;
    // any glyph row above 63 once the blink bit is ignored
    always @* begin
        glyph_bad = 1'b0;
        for (j = 1; j < 9; j = j + 1) if (cmd_b[j][6]) glyph_bad = 1'b1;
    end
    // readback byte for the current loop step
    reg [7:0] rb_byte;
    reg [4:0] rb_col;
    always @* begin
        rb_col = rb_base_q[4:0] + idx_q[4:0];
        if (rb_glyph_q) begin
            rb_byte = glyph_q[rb_base_q[5:0] + idx_q[5:0]];
        end else if (rb_col < `LCDCH_COLS) begin
            rb_byte = text_q[rb_base_q[6:5] * 7'd20 + {2'b00, rb_col}];
        end else begin
            rb_byte = `LCDCH_SPACE; // past the end of the line
        end
    end
    ////////////////////////////////////////////////////////////////////////
    // sequencer: every command path ends in S_DONE within about 90 cycles
    always @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= S_FILL;
            op_q <= OP_LOAD;
            idx_q <= 7'd0;
            post_q <= 1'b0;
            rsp_rdy_q <= 1'b0;
            rsp_event_o <= 1'b0;
            rsp_type_q <= 8'h00;
            rsp_len_q <= 8'h00;
            nv_valid_q <= 1'b0;
            rb_glyph_q <= 1'b0;
            rb_base_q <= 7'd0;
            col_q <= 5'd0;
            row_q <= 2'd0;
            style_q <= 3'd0;
            pulse_cnt_q <= 16'h0000;
            host_reset_o <= 1'b0;
            host_power_off_o <= 1'b0;
            for (i = 0; i < 24; i = i + 1) rsp_b[i] <= 8'h00;
            for (i = 0; i < 16; i = i + 1) nv_user[i] <= 8'h00;
        end else begin
            rsp_event_o <= 1'b0;
            rsp_rdy_q <= rsp_rdy_q & ~rdy_clr; // cleared by software
            // host pin pulse timer
            if (pulse_cnt_q != 16'h0000) begin
                pulse_cnt_q <= pulse_cnt_q - 16'h0001;
            end else begin
                host_reset_o <= 1'b0;
                host_power_off_o <= 1'b0;
            end
            case (state_q)
            S_IDLE: if (go) state_q <= S_EXEC;
            S_EXEC: begin
                state_q <= S_DONE;
                rsp_type_q <= {`LCDCH_CLS_RSP, code};
                rsp_len_q <= 8'h00;
                for (i = 0; i < 24; i = i + 1) rsp_b[i] <= 8'h00;
                if (cmd_type_q[7:6] != `LCDCH_CLS_CMD || cmd_len_q > `LCDCH_MAX_LEN) begin
                    rsp_type_q <= {`LCDCH_CLS_ERR, code};
                end else begin
                    case (code)
                    6'd0: begin
                        if (cmd_len_q <= `LCDCH_PING_MAX) begin
                            rsp_len_q <= cmd_len_q;
                            for (i = 0; i < 16; i = i + 1) rsp_b[i] <= cmd_b[i];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd1: begin
                        if (cmd_len_q == 8'h00) begin
                            rsp_len_q <= 8'h10;
                            for (i = 0; i < 16; i = i + 1) rsp_b[i] <= VERSION_STR[127 - 8 * i -: 8];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd2: begin
                        if (cmd_len_q == 8'h10) begin
                            for (i = 0; i < 16; i = i + 1) nv_user[i] <= cmd_b[i];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd3: begin
                        if (cmd_len_q == 8'h00) begin
                            rsp_len_q <= 8'h10;
                            for (i = 0; i < 16; i = i + 1) rsp_b[i] <= nv_user[i];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd4: begin
                        // only display state exists here, so nothing else is saved
                        if (cmd_len_q == 8'h00) begin
                            nv_col <= col_q;
                            nv_row <= row_q;
                            nv_style <= style_q;
                            nv_valid_q <= 1'b1;
                            op_q <= OP_SAVE;
                            idx_q <= 7'd0;
                            post_q <= 1'b1;
                            state_q <= S_FILL;
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd5: begin
                        if (cmd_len_q == 8'h03 && key == `LCDCH_KEY_BOOT) begin
                            op_q <= OP_LOAD;
                            idx_q <= 7'd0;
                            post_q <= 1'b1;
                            state_q <= S_FILL;
                        end else if (cmd_len_q == 8'h03 && key == `LCDCH_KEY_HRST) begin
                            host_reset_o <= 1'b1;
                            host_power_off_o <= 1'b0;
                            pulse_cnt_q <= HOST_PULSE_CYCLES - 16'h0001; // pin falls as the count ends
                        end else if (cmd_len_q == 8'h03 && key == `LCDCH_KEY_HOFF) begin
                            host_power_off_o <= 1'b1;
                            host_reset_o <= 1'b0;
                            pulse_cnt_q <= HOST_PULSE_CYCLES - 16'h0001;
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd6: begin
                        if (cmd_len_q == 8'h00) begin
                            col_q <= 5'd0;
                            row_q <= 2'd0;
                            op_q <= OP_CLEAR;
                            idx_q <= 7'd0;
                            post_q <= 1'b1;
                            state_q <= S_FILL;
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd9: begin
                        // index byte, then eight rows top first, bit 7 kept for blink
                        if (cmd_len_q == 8'h09 && cmd_b[0] < 8'h08 && !glyph_bad) begin
                            for (i = 0; i < 8; i = i + 1) begin
                                glyph_q[{cmd_b[0][2:0], 3'b000} + i] <= cmd_b[i + 1];
                            end
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd10: begin
                        if (cmd_len_q == 8'h01 && (ra_glyph || ra_text)) begin
                            rsp_len_q <= 8'h09;
                            rsp_b[0] <= ra;
                            rb_glyph_q <= ra_glyph;
                            rb_base_q <= ra[6:0];
                            idx_q <= 7'd0;
                            state_q <= S_READ;
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd11: begin
                        if (cmd_len_q == 8'h02 && cmd_b[0] < {3'b000, `LCDCH_COLS} && cmd_b[1] <= 8'h03) begin
                            col_q <= cmd_b[0][4:0];
                            row_q <= cmd_b[1][1:0];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    6'd12: begin
                        if (cmd_len_q == 8'h01 && cmd_b[0] <= `LCDCH_STYLE_MAX) begin
                            style_q <= cmd_b[0][2:0];
                        end else rsp_type_q <= {`LCDCH_CLS_ERR, code};
                    end
                    default: rsp_type_q <= {`LCDCH_CLS_ERR, code}; // unknown here
                    endcase
                end
            end
            S_FILL: begin
                // one text byte per cycle, and for save and load one glyph byte while in range
                case (op_q)
                OP_CLEAR: text_q[idx_q] <= `LCDCH_SPACE;
                OP_SAVE: begin
                    nv_text[idx_q] <= text_q[idx_q];
                    if (idx_q <= `LCDCH_GLYPH_LAST) nv_glyph[idx_q[5:0]] <= glyph_q[idx_q[5:0]];
                end
                default: begin
                    // no saved copy yet: factory welcome is a blank screen
                    text_q[idx_q] <= nv_valid_q ? nv_text[idx_q] : `LCDCH_SPACE;
                    if (idx_q <= `LCDCH_GLYPH_LAST) begin
                        glyph_q[idx_q[5:0]] <= nv_valid_q ? nv_glyph[idx_q[5:0]] : 8'h00;
                    end
                    col_q <= nv_valid_q ? nv_col : 5'd0;
                    row_q <= nv_valid_q ? nv_row : 2'd0;
                    style_q <= nv_valid_q ? nv_style : 3'd0;
                end
                endcase
                idx_q <= idx_q + 7'd1;
                if (idx_q == `LCDCH_TEXT_LAST) begin
                    state_q <= post_q ? S_DONE : S_IDLE; // power-up load posts nothing
                end
            end
            S_READ: begin
                rsp_b[{2'b00, idx_q[2:0]} + 5'd1] <= rb_byte; // wide so the last byte cannot wrap
                idx_q <= idx_q + 7'd1;
                if (idx_q == 7'd7) state_q <= S_DONE;
            end
            S_DONE: begin
                rsp_rdy_q <= 1'b1; // set wins over clear
                rsp_event_o <= 1'b1;
                post_q <= 1'b0;
                state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// File: verification/lcdch_monitor.sv
module lcdch_monitor #(
    parameter [15:0] HOST_PULSE_CYCLES = 16'h0008 // pin pulse length
) (
    input wire aclk, // clock
    input wire aresetn, // reset, low
    input wire s_axi_awvalid, // aw
    input wire s_axi_awready, // aw
    input wire s_axi_wvalid, // w
    input wire s_axi_wready, // w
    input wire s_axi_bvalid, // b
    input wire s_axi_bready, // b
    input wire s_axi_arvalid, // ar
    input wire s_axi_arready, // ar
    input wire s_axi_rvalid, // r
    input wire s_axi_rready, // r
    input wire host_reset_o, // host pin
    input wire host_power_off_o, // host pin
    input wire rsp_event_o // answer pulse
);
    timeunit 1ns;
    timeprecision 1ps;
    // how long host reset has stood; a counter, as the pulse may be long
    logic [15:0] rst_cnt_q;
    always_ff @(posedge aclk) begin
        if (!aresetn || !host_reset_o) rst_cnt_q <= 16'h0000;
        else rst_cnt_q <= rst_cnt_q + 16'h0001;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_rst_len; $fell(host_reset_o) |-> rst_cnt_q == HOST_PULSE_CYCLES; endproperty
    a_rst_len: assert property (p_rst_len) else $error("host reset pulse length wrong");
    property p_off_len; $rose(host_power_off_o) |-> host_power_off_o[*8] ##1 !host_power_off_o; endproperty
    a_off_len: assert property (p_off_len) else $error("power off pulse length wrong");
    property p_excl; !(host_reset_o && host_power_off_o); endproperty
    a_excl: assert property (p_excl) else $error("both host pins high");
    property p_evt; rsp_event_o |=> !rsp_event_o; endproperty
    a_evt: assert property (p_evt) else $error("answer pulse too long");
    property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wr: assert property (p_wr) else $error("write not answered");
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("write answer dropped");
    property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read not answered");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
    a_rhold: assert property (p_rhold) else $error("read answer dropped");
    c_evt: cover property (rsp_event_o);
    c_rst: cover property ($rose(host_reset_o));
    c_off: cover property ($rose(host_power_off_o));
endmodule
bind lcdch_top lcdch_monitor #(.HOST_PULSE_CYCLES(HOST_PULSE_CYCLES)) u_mon (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .host_reset_o, .host_power_off_o,
    .rsp_event_o);

// File: verification/lcdch_host_model.sv
// host side of the power pins: pins stay in default drive, widths are logged
module lcdch_host_model (
    input wire aclk, // clock
    input wire host_reset, // reset line in
    input wire host_power_off, // power line in
    output int rst_width, // last reset width
    output int off_width // last power off width
);
    timeunit 1ns;
    timeprecision 1ps;
    int run_r = 0; // running widths
    int run_o = 0;
    always @(negedge aclk) begin
        if (!host_reset && run_r != 0) rst_width = run_r;
        run_r = host_reset ? run_r + 1 : 0;
        if (!host_power_off && run_o != 0) off_width = run_o;
        run_o = host_power_off ? run_o + 1 : 0;
    end
endmodule

// File: verification/lcdch_top_bench.sv
module lcdch_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ah, wh, bh, bt;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, v;
    logic [1:0] r;
    wire awready, wready, bvalid, arready, rvalid, hrst, hoff, evt;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    int err_total = 0, n_tests = 0, ev_n = 0, rst_w, off_w;
    localparam logic [127:0] PAT = 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100;
    initial forever #12.5 aclk = ~aclk;
    lcdch_top #(.HOST_PULSE_CYCLES(16'h0008)) u_dut (.aclk, .aresetn, .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .host_reset_o(hrst), .host_power_off_o(hoff), .rsp_event_o(evt));
    lcdch_host_model u_host (.aclk, .host_reset(hrst), .host_power_off(hoff), .rst_width(rst_w), .off_width(off_w));
    // answer pulses counted at the falling edge, clear of the launching edge
    always @(negedge aclk) if (evt === 1'b1) ev_n++;
    task chk(input [31:0] got, input [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // ready is raised only once the answer shows, so the hold path is exercised
    task wr(input [7:0] a, input [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid} <= {a, d, 2'b11};
        forever begin
            @(negedge aclk);
            {ah, wh, bh, bt, r} = {awvalid && awready, wvalid && wready, bvalid, bvalid && bready, bresp};
            @(posedge aclk);
            if (ah) awvalid <= 0;
            if (wh) wvalid <= 0;
            bready <= bh && !bt;
            if (bt) break;
        end
    endtask
    task rd(input [7:0] a);
        @(posedge aclk);
        {araddr, arvalid} <= {a, 1'b1};
        forever begin
            @(negedge aclk);
            {ah, bh, bt, v, r} = {arvalid && arready, rvalid, rvalid && rready, rdata, rresp};
            @(posedge aclk);
            if (ah) arvalid <= 0;
            rready <= bh && !bt;
            if (bt) break;
        end
    endtask
    // one command: header, payload, go, wait for the answer, clear ready
    task cmd(input [15:0] tl, input [127:0] p, input [15:0] exp);
        int e0;
        wr(8'h04, {16'h0000, tl});
        for (int i = 0; i < 4; i++) wr(8'h08 + 8'(4 * i), p[32 * i +: 32]);
        e0 = ev_n;
        wr(8'h00, 32'h0000_0001);
        v = '0;
        for (int i = 0; i < 200 && v[1] !== 1'b1; i++) rd(8'h20);
        chk(ev_n - e0, 1);
        rd(8'h24);
        chk(v[15:0], exp);
        wr(8'h20, 32'h0000_0002);
    endtask
    task rdat(input [127:0] e);
        for (int i = 0; i < 4; i++) begin
            rd(8'h28 + 8'(4 * i));
            chk(v, e[32 * i +: 32]);
        end
    endtask
    task t_misc;
        cmd(16'h0001, '0, 16'h1041);
        cmd(16'h0004, '0, 16'h0044);
        cmd(16'h0007, '0, 16'h00c7);
        cmd(16'h0081, '0, 16'h00c1);
        wr(8'h44, '0);
        chk(r, 2'b10);
        rd(8'h44);
        chk(r, 2'b10);
        $display("misc test done");
    endtask
    task t_data;
        cmd(16'h1000, PAT, 16'h1040);
        rdat(PAT);
        cmd(16'h1100, PAT, 16'h00c0);
        cmd(16'h1002, ~PAT, 16'h0042);
        cmd(16'h0f02, PAT, 16'h00c2);
        cmd(16'h0003, '0, 16'h1043);
        rdat(~PAT);
        $display("data test done");
    endtask
    task t_screen;
        cmd(16'h020b, 128'h0313, 16'h004b);
        cmd(16'h020b, 128'h0314, 16'h00cb);
        cmd(16'h170b, 128'h0000, 16'h00cb);
        for (int s = 0; s < 5; s++) cmd(16'h010c, 128'(s), 16'h004c);
        cmd(16'h010c, 128'h05, 16'h00cc);
        rd(8'h20);
        chk({v[20:16], v[12:8]}, 10'h273);
        cmd(16'h0006, '0, 16'h0046);
        rd(8'h20);
        chk(v[17:8], 10'h000);
        for (int l = 0; l < 4; l++) begin
            cmd(16'h010a, 128'(8'h80 + 8'(32 * l)), 16'h094a);
            rd(8'h28);
            chk(v, {24'h20_2020, 8'h80 + 8'(32 * l)});
        end
        cmd(16'h0909, 128'h0000_008c_2a15_0020_3f01_9f01, 16'h0049);
        cmd(16'h0909, 128'h4001, 16'h00c9);
        cmd(16'h010a, 128'h48, 16'h094a);
        rdat(128'h0000_008c_2a15_0020_3f01_9f48);
        $display("screen test done");
    endtask
    task t_restart;
        cmd(16'h0305, 128'h0061_1c0c, 16'h0045);
        repeat (20) @(posedge aclk);
        chk(rst_w, 8);
        cmd(16'h0305, 128'h005f_0b03, 16'h0045);
        repeat (20) @(posedge aclk);
        chk(off_w, 8);
        cmd(16'h0305, 128'h0062_1208, 16'h00c5);
        cmd(16'h0305, 128'h0063_1208, 16'h0045);
        rd(8'h20);
        chk(v[20:16], 5'h00);
        $display("restart test done");
    endtask
    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1;
        repeat (100) @(posedge aclk);
        t_misc;
        t_data;
        t_screen;
        t_restart;
        conclude;
    end
    // the tests need a few thousand cycles; this bounds a hang
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        conclude;
    end
endmodule
